// ### core/riqm_monitor.sv
// reference input quality monitor: activity, frequency, leaky accumulator, fast loss
`timescale 1ns/1ps
module riqm_monitor import riqm_pkg::*; #(
	parameter int ASSESS_CYCLES = ASSESS_CYC,
	parameter int LOS_CYCLES    = LOS_CYC,
	parameter int GATE_CYCLES   = GATE_CYC
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 nrst_in,
	input  wire logic [NUM_CH-1:2]    ref_in,
	input  wire logic [AMI_CH-1:0]    ami_pos_in,
	input  wire logic [AMI_CH-1:0]    ami_neg_in,
	input  wire logic                 master_slave_pin_in,
	input  wire logic                 network_type_pin_in,
	input  wire logic                 net_type_wr_in,
	input  wire logic                 net_type_in,
	input  wire logic                 diff_std_wr_in,
	input  wire logic [1:0]           diff_std_in,
	input  wire logic                 prio_wr_in,
	input  wire logic                 freq_wr_in,
	input  wire logic [3:0]           wr_ch_in,
	input  wire logic [3:0]           wr_prio_in,
	input  wire logic [3:0]           wr_freq_in,
	input  wire logic [LBW-1:0]       lb_size_in,
	input  wire logic [LBW-1:0]       lb_upper_in,
	input  wire logic [LBW-1:0]       lb_lower_in,
	input  wire logic [1:0]           lb_decay_in,
	input  wire logic [CW-1:0]        freq_tol_in,
	input  wire logic [3:0]           sel_ch_in,
	input  wire logic                 fb_edge_in,
	input  wire logic                 phase_lost_in,
	input  wire logic                 phase_lost_en_in,
	input  wire logic                 main_fail_clr_in,
	output logic                      network_type_select_out,
	output logic [1:0]                diff_std_out,
	output logic [NUM_CH*4-1:0]       prio_out,
	output logic [NUM_CH*4-1:0]       freq_out,
	output logic [NUM_CH-1:0]         activity_lost_out,
	output logic [NUM_CH-1:0]         out_of_band_out,
	output logic [NUM_CH-1:0]         lb_alarm_out,
	output logic [NUM_CH-1:0]         unavailable_out,
	output logic                      main_ref_failed_out,
	output logic                      holdover_out,
	output logic [CW:0]               phase_err_out
);
	// ************
	// configuration state
	// ************
	logic [1:0]  init_r, init_nxt;
	logic        ms_s1_r, ms_s2_r, nt_s1_r, nt_s2_r;
	logic        net_r, net_nxt;
	logic [1:0]  dstd_r, dstd_nxt;
	logic [3:0]  prio_r [NUM_CH];
	logic [3:0]  prio_nxt [NUM_CH];
	riqm_freq_e  freq_r [NUM_CH];
	riqm_freq_e  freq_nxt [NUM_CH];

	// strap defaults, software writes, mode-driven rate updates
	always_comb begin
		logic [3:0] wi;
		wi = wr_ch_in - CH_FIRST;
		init_nxt = (init_r == 2'h3) ? init_r : init_r + 2'h1;
		net_nxt = net_r;
		dstd_nxt = dstd_r;
		prio_nxt = prio_r;
		freq_nxt = freq_r;
		if (init_r == 2'h2) begin
			net_nxt = nt_s2_r;
			for (int c = 0; c < NUM_CH; c++) begin
				prio_nxt[c] = riqm_def_prio(c, ms_s2_r);
				freq_nxt[c] = riqm_def_freq(c, nt_s2_r, ms_s2_r);
			end
		end else if (init_r == 2'h3) begin
			if (net_type_wr_in) begin
				net_nxt = net_type_in;
				for (int c = 0; c < NUM_CH; c++) begin
					if (freq_r[c] == F_1M544 || freq_r[c] == F_2M048)
						freq_nxt[c] = net_type_in ? F_1M544 : F_2M048;
				end
			end
			if (diff_std_wr_in)
				dstd_nxt = diff_std_in;
			if (wr_ch_in >= CH_FIRST && wr_ch_in <= CH_LAST) begin
				if (prio_wr_in)
					prio_nxt[wi] = wr_prio_in;
				if (freq_wr_in && wr_freq_in <= F_155M52
					&& riqm_valid(int'(wi), riqm_freq_e'(wr_freq_in)))
					freq_nxt[wi] = riqm_freq_e'(wr_freq_in);
			end
		end
	end

	// configuration registers; straps caught after reset release
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			init_r <= 2'h0;
			{ms_s1_r, ms_s2_r, nt_s1_r, nt_s2_r} <= 4'h0;
			net_r <= 1'b0;
			dstd_r <= DSTD_RST;
			for (int c = 0; c < NUM_CH; c++) begin
				prio_r[c] <= riqm_def_prio(c, 1'b1);
				freq_r[c] <= riqm_def_freq(c, 1'b0, 1'b1);
			end
		end else begin
			init_r <= init_nxt;
			{ms_s1_r, ms_s2_r} <= {master_slave_pin_in, ms_s1_r};
			{nt_s1_r, nt_s2_r} <= {network_type_pin_in, nt_s1_r};
			net_r <= net_nxt;
			dstd_r <= dstd_nxt;
			prio_r <= prio_nxt;
			freq_r <= freq_nxt;
		end
	end

	// ************
	// period ticks
	// ************
	logic [22:0] as_cnt_r, as_cnt_nxt;
	logic [15:0] gt_cnt_r, gt_cnt_nxt;
	logic [2:0]  lk_cnt_r, lk_cnt_nxt;
	logic        as_tick, gt_tick, lk_tick;

	// assessment, gate and leak dividers
	always_comb begin
		as_tick = as_cnt_r == 23'(ASSESS_CYCLES - 1);
		gt_tick = gt_cnt_r == 16'(GATE_CYCLES - 1);
		lk_tick = as_tick && ((lk_cnt_r & ((3'h1 << lb_decay_in) - 3'h1)) == 3'h0);
		as_cnt_nxt = as_tick ? 23'h0 : as_cnt_r + 23'h1;
		gt_cnt_nxt = gt_tick ? 16'h0 : gt_cnt_r + 16'h1;
		lk_cnt_nxt = as_tick ? lk_cnt_r + 3'h1 : lk_cnt_r;
	end

	// divider registers
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			as_cnt_r <= 23'h0;
			gt_cnt_r <= 16'h0;
			lk_cnt_r <= 3'h0;
		end else begin
			as_cnt_r <= as_cnt_nxt;
			gt_cnt_r <= gt_cnt_nxt;
			lk_cnt_r <= lk_cnt_nxt;
		end
	end

	// ************
	// per-input monitors
	// ************
	logic          edge_w [NUM_CH];
	logic [CW-1:0] gap_w [NUM_CH];
	logic [CW-1:0] per_w [NUM_CH];

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic          p1_r, p2_r, p3_r, n1_r, n2_r, n3_r;
		logic          ed, err, lp_r, lp_nxt, loss;
		logic [2:0]    k_r, k_nxt;
		logic [CW-1:0] gap_r, gap_nxt, per_r, per_nxt, cnt_r, cnt_nxt, nom, dif;
		logic          irr_r, irr_nxt, oob_r, oob_nxt, alm_r, alm_nxt;
		logic [LBW-1:0] acc_r, acc_nxt;
		logic          pp, np, viol;

		// edge detect after the two-flop synchroniser; AMI pulses on either rail
		always_comb begin
			pp = p2_r & ~p3_r;
			np = n2_r & ~n3_r;
			ed = (i < AMI_CH) ? (pp | np) : pp;
			viol = (pp & lp_r) | (np & ~lp_r); // same polarity twice
			err = 1'b0;
			lp_nxt = lp_r;
			k_nxt = k_r;
			if (i < AMI_CH && (pp | np)) begin
				lp_nxt = pp;
				err = viol ? (k_r != 3'h7) : (k_r == 3'h7);
				k_nxt = viol ? 3'h0 : k_r + 3'h1;
			end
		end

		// activity, frequency and accumulator next values
		always_comb begin
			loss = gap_r >= CW'(LOS_CYCLES);
			gap_nxt = ed ? '0 : (&gap_r ? gap_r : gap_r + 17'h1);
			per_nxt = ed ? gap_r + 17'h1 : per_r;
			cnt_nxt = gt_tick ? {16'h0, ed} : cnt_r + {16'h0, ed};
			nom = riqm_nominal(freq_r[i]);
			dif = (cnt_r > nom) ? cnt_r - nom : nom - cnt_r;
			oob_nxt = oob_r;
			if (gt_tick && !irr_r && !loss)
				oob_nxt = (nom != '0) && (dif > freq_tol_in);
			irr_nxt = as_tick ? (loss | err) : (irr_r | loss | err);
			acc_nxt = acc_r;
			if (as_tick && irr_r)
				acc_nxt = (acc_r < lb_size_in) ? acc_r + 5'h1 : lb_size_in;
			else if (lk_tick && acc_r != '0)
				acc_nxt = acc_r - 5'h1;
			alm_nxt = alm_r;
			if (acc_r >= lb_upper_in)
				alm_nxt = 1'b1;
			else if (acc_r <= lb_lower_in)
				alm_nxt = 1'b0;
		end

		// channel registers
		always_ff @(posedge core_clk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				{p1_r, p2_r, p3_r, n1_r, n2_r, n3_r} <= 6'h0;
				lp_r <= 1'b0;
				k_r <= 3'h0;
				gap_r <= '1;
				per_r <= '0;
				cnt_r <= '0;
				irr_r <= 1'b0;
				oob_r <= 1'b0;
				acc_r <= '0;
				alm_r <= 1'b0;
			end else begin
				p1_r <= (i < AMI_CH) ? ami_pos_in[i % AMI_CH] : ref_in[i < 2 ? 2 : i];
				n1_r <= ami_neg_in[i % AMI_CH];
				{p2_r, p3_r, n2_r, n3_r} <= {p1_r, p2_r, n1_r, n2_r};
				lp_r <= lp_nxt;
				k_r <= k_nxt;
				gap_r <= gap_nxt;
				per_r <= per_nxt;
				cnt_r <= cnt_nxt;
				irr_r <= irr_nxt;
				oob_r <= oob_nxt;
				acc_r <= acc_nxt;
				alm_r <= alm_nxt;
			end
		end

		assign edge_w[i] = ed;
		assign gap_w[i] = gap_r;
		assign per_w[i] = per_r;
		assign activity_lost_out[i] = loss;
		assign out_of_band_out[i] = oob_r;
		assign lb_alarm_out[i] = alm_r;
		assign unavailable_out[i] = loss | oob_r | alm_r;
		assign prio_out[i*4 +: 4] = prio_r[i];
		assign freq_out[i*4 +: 4] = freq_r[i];
	end

	// ************
	// selected reference: fast loss and phase
	// ************
	logic [3:0]    si;
	logic          sel_ok, miss, fail_r, fail_nxt;
	logic [CW-1:0] ph_r, ph_nxt, sper;
	logic [CW:0]   perr_r, perr_nxt;

	// only the selected input may drive holdover and phase
	always_comb begin
		si = sel_ch_in - CH_FIRST;
		sel_ok = sel_ch_in >= CH_FIRST && sel_ch_in <= CH_LAST;
		sper = sel_ok ? per_w[si] : '0;
		miss = sel_ok && sper != '0
			&& {1'b0, gap_w[si]} > (CW + 1)'(FAST_MISS) * {1'b0, sper};
		fail_nxt = (fail_r & ~main_fail_clr_in) | miss
			| (phase_lost_in & phase_lost_en_in);
		ph_nxt = fb_edge_in ? '0 : ph_r + 17'h1;
		perr_nxt = perr_r;
		if (sel_ok && edge_w[si])
			perr_nxt = (ph_r > (sper >> 1)) ? {1'b0, ph_r} - {1'b0, sper}
				: {1'b0, ph_r};
		holdover_out = miss | (sel_ok & unavailable_out[si]);
	end

	// fast flag and phase registers
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fail_r <= 1'b0;
			ph_r <= '0;
			perr_r <= '0;
		end else begin
			fail_r <= fail_nxt;
			ph_r <= ph_nxt;
			perr_r <= perr_nxt;
		end
	end

	assign main_ref_failed_out = fail_r;
	assign phase_err_out = perr_r;
	assign network_type_select_out = net_r;
	assign diff_std_out = dstd_r;
endmodule : riqm_monitor

// ### include/riqm_pkg.sv
// constants and helpers shared by the reference input quality monitor
package riqm_pkg;
	// ************
	// dimensions and timing
	// ************
	localparam int NUM_CH     = 14;         // reference inputs, codes 0001..1110
	localparam int AMI_CH     = 2;          // first two inputs are AMI composite clocks
	localparam int DIFF_A     = 4;          // fifth input, differential
	localparam int DIFF_B     = 5;          // sixth input, differential
	localparam int CW         = 17;         // monitor counter width
	localparam int LBW        = 5;          // leaky accumulator width
	localparam int CLK_HZ     = 40_000_000;
	localparam int ASSESS_MS  = 128;        // irregularity assessment period
	localparam int LOS_MS     = 1;          // no-activity time to loss of signal
	localparam int GATE_MS    = 1;          // frequency count gate
	localparam int ASSESS_CYC = CLK_HZ / 1000 * ASSESS_MS;
	localparam int LOS_CYC    = CLK_HZ / 1000 * LOS_MS;
	localparam int GATE_CYC   = CLK_HZ / 1000 * GATE_MS;
	localparam int FAST_MISS  = 2;          // missing cycles before the fast flag
	localparam logic [3:0] CH_FIRST  = 4'h1;
	localparam logic [3:0] CH_LAST   = 4'hE;
	localparam logic [3:0] PRIO_BASE = 4'h2; // priority of the first input
	localparam logic [3:0] PRIO_SLV  = 4'h1; // eleventh input in slave mode
	localparam int SLV_CH     = 10;         // eleventh input
	localparam logic [1:0] DSTD_RST  = 2'h1; // bit0 fifth, bit1 sixth; 1 = LVDS

	// spot frequencies
	typedef enum logic [3:0] {
		F_2K, F_4K, F_8K, F_NX8K, F_64K_CC, F_1M544, F_2M048, F_6M48,
		F_19M44, F_25M92, F_38M88, F_51M84, F_77M76, F_155M52
	} riqm_freq_e;

	// expected edges per gate, zero when no check applies
	function automatic logic [CW-1:0] riqm_nominal(input riqm_freq_e f);
		unique case (f)
			F_2K:     return 17'h00002;
			F_4K:     return 17'h00004;
			F_8K:     return 17'h00008;
			F_64K_CC: return 17'h00040;
			F_1M544:  return 17'h00608;
			F_2M048:  return 17'h00800;
			F_6M48:   return 17'h01950;
			F_19M44:  return 17'h04BF0;
			default:  return 17'h00000;
		endcase
	endfunction : riqm_nominal

	// power-up priority of an input
	function automatic logic [3:0] riqm_def_prio(input int c, input logic master);
		if (c == SLV_CH && !master) return PRIO_SLV;
		return PRIO_BASE + c[3:0];
	endfunction : riqm_def_prio

	// power-up frequency of an input
	function automatic riqm_freq_e riqm_def_freq(input int c, input logic son,
		input logic master);
		if (c < AMI_CH) return F_64K_CC;
		if (c < 4) return F_8K;
		if (c < SLV_CH) return F_19M44;
		if (c == SLV_CH && !master) return F_6M48;
		return son ? F_1M544 : F_2M048;
	endfunction : riqm_def_freq

	// spot frequencies each port technology accepts
	function automatic logic riqm_valid(input int c, input riqm_freq_e f);
		if (c < AMI_CH) return f == F_64K_CC;
		if (f == F_64K_CC) return 1'b0;
		if (f == F_155M52) return c == DIFF_A || c == DIFF_B;
		return 1'b1;
	endfunction : riqm_valid
endpackage : riqm_pkg

// ### verification/riqm_monitor_bench.sv
// self-checking bench for the reference input quality monitor
`timescale 1ns/1ps
`define CHK(n, e, s) begin #1; checks++; if ((s) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %0h seen %0h", n, e, s); end end
module riqm_monitor_bench;
	import riqm_pkg::*;
	localparam int LOS = 50;
	logic	core_clk_in, nrst_in, master_slave_pin_in, network_type_pin_in, fb_edge_in;
	logic	net_type_wr_in, net_type_in, diff_std_wr_in, prio_wr_in, freq_wr_in;
	logic	phase_lost_in, phase_lost_en_in, main_fail_clr_in, network_type_select_out;
	logic	main_ref_failed_out, holdover_out;
	logic [1:0]	diff_std_in, lb_decay_in, diff_std_out, ami_pos_in, ami_neg_in, ami_bad;
	logic [3:0]	wr_ch_in, wr_prio_in, wr_freq_in, sel_ch_in;
	logic [LBW-1:0]	lb_size_in, lb_upper_in, lb_lower_in;
	logic [CW-1:0]	freq_tol_in;
	logic [CW:0]	phase_err_out;
	logic [NUM_CH-1:2]	ref_in;
	logic [NUM_CH*4-1:0]	prio_out, freq_out;
	logic [NUM_CH-1:0]	activity_lost_out, out_of_band_out, lb_alarm_out, unavailable_out, run;
	int	bad_count = 0;
	int	checks = 0;
	riqm_monitor #(.ASSESS_CYCLES(200), .LOS_CYCLES(LOS), .GATE_CYCLES(64)) u_riqm_monitor (
		.core_clk_in, .nrst_in, .ref_in, .ami_pos_in, .ami_neg_in, .master_slave_pin_in,
		.network_type_pin_in, .net_type_wr_in, .net_type_in, .diff_std_wr_in, .diff_std_in,
		.prio_wr_in, .freq_wr_in, .wr_ch_in, .wr_prio_in, .wr_freq_in, .lb_size_in,
		.lb_upper_in, .lb_lower_in, .lb_decay_in, .freq_tol_in, .sel_ch_in, .fb_edge_in,
		.phase_lost_in, .phase_lost_en_in, .main_fail_clr_in, .network_type_select_out,
		.diff_std_out, .prio_out, .freq_out, .activity_lost_out, .out_of_band_out,
		.lb_alarm_out, .unavailable_out, .main_ref_failed_out, .holdover_out, .phase_err_out);
	riqm_ref_src u_riqm_ref_src (.clk_in(core_clk_in), .run_in(run), .ami_bad_in(ami_bad),
		.ref_out(ref_in), .pos_out(ami_pos_in), .neg_out(ami_neg_in), .fb_out(fb_edge_in));
	// 40 MHz system clock
	always #12.5 core_clk_in = ~core_clk_in;
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk_in);
	endtask : cyc
	// one configuration write: 0 priority, 1 frequency, 2 network type, 3 signalling
	task automatic wr(input int k, input logic [3:0] c, input logic [3:0] v);
		@(posedge core_clk_in);
		prio_wr_in <= k == 0;
		freq_wr_in <= k == 1;
		net_type_wr_in <= k == 2;
		diff_std_wr_in <= k == 3;
		wr_ch_in <= c;
		wr_prio_in <= v;
		wr_freq_in <= v;
		net_type_in <= v[0];
		diff_std_in <= v[1:0];
		@(posedge core_clk_in);
		{prio_wr_in, freq_wr_in, net_type_wr_in, diff_std_wr_in} <= 4'h0;
		@(posedge core_clk_in);
	endtask : wr
	task automatic t_defaults(input logic ms, input logic nt);
		logic [3:0] ep;
		logic [3:0] ef;
		@(posedge core_clk_in);
		master_slave_pin_in <= ms;
		network_type_pin_in <= nt;
		nrst_in <= 1'b0;
		cyc(8);
		nrst_in <= 1'b1;
		cyc(6);
		for (int c = 1; c <= NUM_CH; c++) begin
			ep = (c == 11 && !ms) ? 4'h1 : 4'(c + 1);
			ef = c <= 2 ? 4'h4 : c <= 4 ? 4'h2 : c <= 10 ? 4'h8 :
				(c == 11 && !ms) ? 4'h7 : nt ? 4'h5 : 4'h6;
			`CHK("prio", ep, prio_out[(c-1)*4+:4])
			`CHK("freq", ef, freq_out[(c-1)*4+:4])
		end
		`CHK("net", nt, network_type_select_out)
		`CHK("dstd", 2'h1, diff_std_out)
		$display("defaults test done");
	endtask : t_defaults
	task automatic t_config();
		wr(3, 4'h0, 4'h2);
		`CHK("dstd", 2'h2, diff_std_out)
		wr(1, 4'h3, 4'hD);
		`CHK("freq3", 4'h2, freq_out[11:8])
		wr(1, 4'h5, 4'hD);
		`CHK("freq5", 4'hD, freq_out[19:16])
		wr(1, 4'h1, 4'h8);
		`CHK("freq1", 4'h4, freq_out[3:0])
		wr(0, 4'h9, 4'h0);
		`CHK("prio9", 4'h0, prio_out[35:32])
		wr(2, 4'h0, 4'h0);
		`CHK("net", 1'b0, network_type_select_out)
		`CHK("freq12", 4'h6, freq_out[47:44])
		$display("config test done");
	endtask : t_config
	task automatic t_activity();
		cyc(1);
		freq_tol_in <= 17'h00040;
		for (int c = 3; c <= NUM_CH; c++) wr(1, 4'(c), c == 3 ? 4'h5 : 4'h3);
		cyc(600);
		`CHK("lost", 14'h0000, activity_lost_out)
		`CHK("band", 14'h0004, out_of_band_out)
		`CHK("unav", 14'h0004, unavailable_out)
		wr(1, 4'h3, 4'h3);
		cyc(300);
		`CHK("band", 14'h0000, out_of_band_out)
		cyc(1);
		run <= 14'h3FF5;
		cyc(LOS - 15);
		`CHK("lost", 14'h0000, activity_lost_out)
		cyc(25);
		`CHK("lost", 14'h000A, activity_lost_out)
		`CHK("unav", 14'h000A, unavailable_out)
		cyc(1);
		run <= '1;
		cyc(50);
		`CHK("lost", 14'h0000, activity_lost_out)
		$display("activity test done");
	endtask : t_activity
	task automatic t_bucket();
		cyc(600);
		lb_upper_in <= 5'h02;
		ami_bad <= 2'h1;
		cyc(150);
		`CHK("alarm", 14'h0000, lb_alarm_out)
		cyc(600);
		`CHK("alarm", 14'h0001, lb_alarm_out)
		cyc(1);
		ami_bad <= 2'h0;
		cyc(1400);
		`CHK("alarm", 14'h0000, lb_alarm_out)
		$display("bucket test done");
	endtask : t_bucket
	task automatic t_fast();
		cyc(1);
		sel_ch_in <= 4'h4;
		main_fail_clr_in <= 1'b1;
		cyc(100);
		main_fail_clr_in <= 1'b0;
		cyc(2);
		`CHK("hold", 1'b0, holdover_out)
		`CHK("fail", 1'b0, main_ref_failed_out)
		cyc(1);
		run <= 14'h3FF7;
		cyc(30);
		`CHK("hold", 1'b1, holdover_out)
		`CHK("fail", 1'b1, main_ref_failed_out)
		`CHK("unav", 1'b0, unavailable_out[3])
		cyc(5);
		run <= '1;
		cyc(20);
		`CHK("hold", 1'b0, holdover_out)
		`CHK("fail", 1'b1, main_ref_failed_out)
		cyc(20);
		`CHK("phase", 1'b1, (phase_err_out == 18'h00000) || (phase_err_out == 18'h00004))
		cyc(1);
		phase_lost_in <= 1'b1;
		main_fail_clr_in <= 1'b1;
		cyc(1);
		main_fail_clr_in <= 1'b0;
		cyc(3);
		`CHK("fail", 1'b0, main_ref_failed_out)
		cyc(1);
		phase_lost_en_in <= 1'b1;
		cyc(3);
		`CHK("fail", 1'b1, main_ref_failed_out)
		$display("fast loss test done");
	endtask : t_fast
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	// cut a hang short well past the expected run length
	initial begin
		cyc(10000);
		bad_count++;
		summarize();
	end
	// time-zero values, then the scenarios in order
	initial begin
		core_clk_in = 1'b0;
		{nrst_in, network_type_pin_in, net_type_wr_in, net_type_in, diff_std_wr_in} = '0;
		{prio_wr_in, freq_wr_in, phase_lost_in, phase_lost_en_in, main_fail_clr_in} = '0;
		{diff_std_in, lb_decay_in, ami_bad, wr_ch_in, wr_prio_in, wr_freq_in, sel_ch_in} = '0;
		master_slave_pin_in = 1'b1;
		lb_size_in = 5'h04;
		lb_upper_in = 5'h1F;
		lb_lower_in = 5'h00;
		freq_tol_in = 17'h1FFFF;
		run = '1;
		t_defaults(1'b1, 1'b0);
		t_defaults(1'b0, 1'b1);
		t_config();
		t_activity();
		t_bucket();
		t_fast();
		summarize();
	end
endmodule : riqm_monitor_bench

// ### verification/riqm_monitor_sva.sv
// assertion checker on the ports of the reference input quality monitor
`timescale 1ns/1ps
module riqm_monitor_sva import riqm_pkg::*; (
	input wire logic		core_clk_in,
	input wire logic		nrst_in,
	input wire logic		net_type_wr_in,
	input wire logic		net_type_in,
	input wire logic		diff_std_wr_in,
	input wire logic [1:0]		diff_std_in,
	input wire logic		freq_wr_in,
	input wire logic [3:0]		wr_ch_in,
	input wire logic [3:0]		wr_freq_in,
	input wire logic [3:0]		sel_ch_in,
	input wire logic		phase_lost_in,
	input wire logic		phase_lost_en_in,
	input wire logic		main_fail_clr_in,
	input wire logic		network_type_select_out,
	input wire logic [1:0]		diff_std_out,
	input wire logic [NUM_CH*4-1:0]	freq_out,
	input wire logic [NUM_CH-1:0]	activity_lost_out,
	input wire logic [NUM_CH-1:0]	out_of_band_out,
	input wire logic [NUM_CH-1:0]	lb_alarm_out,
	input wire logic [NUM_CH-1:0]	unavailable_out,
	input wire logic		main_ref_failed_out,
	input wire logic		holdover_out
);
	logic [2:0]	up_r;
	logic [2:0]	up_nxt;
	// edges since reset; writes only count once strap loading is over
	always_comb up_nxt = up_r[2] ? up_r : up_r + 3'h1;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) up_r <= 3'h0;
		else up_r <= up_nxt;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	a_unavail_union: assert property (unavailable_out ==
		(activity_lost_out | out_of_band_out | lb_alarm_out)) else $error("unavailable mismatch");
	a_band_gated: assert property ((out_of_band_out & ~$past(out_of_band_out)
		& $past(activity_lost_out)) == '0) else $error("band alarm while lost");
	a_fail_held: assert property (main_ref_failed_out && !main_fail_clr_in
		|=> main_ref_failed_out) else $error("loss flag dropped");
	a_fail_clear: assert property (main_fail_clr_in && !holdover_out &&
		!(phase_lost_in && phase_lost_en_in) |=> !main_ref_failed_out) else $error("no clear");
	a_phase_flag: assert property (phase_lost_in && phase_lost_en_in
		|=> main_ref_failed_out) else $error("phase loss not flagged");
	a_no_sel_hold: assert property (sel_ch_in == 4'h0 || sel_ch_in == 4'hF
		|-> !holdover_out) else $error("holdover without selection");
	a_freq_refuse: assert property (up_r[2] && freq_wr_in && wr_freq_in == 4'hD &&
		!(wr_ch_in inside {4'h5, 4'h6}) |=> $stable(freq_out)) else $error("code taken");
	a_net_write: assert property (up_r[2] && net_type_wr_in
		|=> network_type_select_out == $past(net_type_in)) else $error("net write lost");
	a_diff_write: assert property (up_r[2] && diff_std_wr_in
		|=> diff_std_out == $past(diff_std_in)) else $error("diff write lost");
endmodule : riqm_monitor_sva
bind riqm_monitor riqm_monitor_sva u_riqm_monitor_sva (.core_clk_in, .nrst_in, .net_type_wr_in,
	.net_type_in, .diff_std_wr_in, .diff_std_in, .freq_wr_in, .wr_ch_in, .wr_freq_in,
	.sel_ch_in, .phase_lost_in, .phase_lost_en_in, .main_fail_clr_in,
	.network_type_select_out, .diff_std_out, .freq_out, .activity_lost_out,
	.out_of_band_out, .lb_alarm_out, .unavailable_out, .main_ref_failed_out, .holdover_out);

// ### verification/riqm_ref_src.sv
// model of the external reference sources and the loop feedback edge
`timescale 1ns/1ps
module riqm_ref_src import riqm_pkg::*; (
	input  wire logic [0:0]		clk_in,
	input  wire logic [NUM_CH-1:0]	run_in,
	input  wire logic [AMI_CH-1:0]	ami_bad_in,
	output logic [NUM_CH-1:2]	ref_out,
	output logic [AMI_CH-1:0]	pos_out,
	output logic [AMI_CH-1:0]	neg_out,
	output logic			fb_out
);
	int	t = 0;
	int	n = 0;
	logic [AMI_CH-1:0]	pol = '0;
	logic	p;
	initial begin
		ref_out = '0;
		pos_out = '0;
		neg_out = '0;
	end
	assign fb_out = t % 8 == 2;
	// clocks of eight system periods; a stopped source holds its level
	always @(posedge clk_in) begin
		t <= t + 1;
		for (int i = 2; i < NUM_CH; i++)
			if (run_in[i] && t % 4 == 0) ref_out[i] <= ~ref_out[i];
	end
	// marks alternate, the eighth repeats polarity unless told to break it
	always @(posedge clk_in) begin
		if (t % 8 == 0) begin
			// a broken frame alternates on its eighth mark, so every frame departs
			for (int i = 0; i < AMI_CH; i++) begin
				p = (n == 7 && !ami_bad_in[i]) ? pol[i] : ~pol[i];
				pos_out[i] <= run_in[i] & p;
				neg_out[i] <= run_in[i] & ~p;
				pol[i] <= p;
			end
			n <= (n + 1) % 8;
		end else if (t % 8 == 4) begin
			pos_out <= '0;
			neg_out <= '0;
		end
	end
endmodule : riqm_ref_src
